// *** logic/midi_sync_interpreter.sv ***
// MIDI and analog sync input interpreter for an eight-voice drum sequencer.
// How it works
// - MIDI clock disabled: drop every timing clock byte, keep own tempo.
// - Two-bit map mode picks all-percussion, specific, note-name or octave mapping.
// - All-percussion mode plays the closest voice for each percussion note.
// - Specific mode maps notes 36,38,39,42,43,46,50,76 to fixed voices.
// - Note-name mode maps naturals C to B onto seven voices, any octave.
// - Note-name mode maps every sharp or flat to the closed hat.
// - Octave mode maps octaves -1 to 9 onto voices, top octave both hats.
// - All-channels on: note-on accepted on every channel.
// - All-channels off: note-on accepted only on the configured channel.
// - Note-on acted upon only in play-drums mode.
// - Real-time messages handled in every mode except play-drums and edit-song.
// - Accepted MIDI clock drives the sequencer instead of internal tempo.
// - Stop halts playback at once.
// - Start plays from the first step.
// - Continue resumes from where playback stopped.
// - Song position zero rewinds; nonzero positions are ignored.
// - Gate input edges act as run button presses.
// - External clock pulses set the sequencer tempo.
// - MIDI and internal clocks count 24 pulses per quarter note; external clock only with the 24-pulse option on.
// - Gate input disabled: gate pin ignored.
// - Clock input disabled: clock pin ignored.
// - 24-pulse option off with external clock: one step per pulse.
`timescale 1ns/1ns
module midi_sync_interpreter #(
  parameter int unsigned SOURCE_TIMEOUT_CYCLES = midi_sync_pkg::SOURCE_TIMEOUT_CYC
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Received MIDI bytes from the serial receiver.
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  // Sync pins.
  input  wire logic        clock_in_pin,
  input  wire logic        gate_in_pin,
  // Sequencer and voice outputs.
  output logic [7:0]       voice_trig,
  output logic             step_pulse,
  output logic             running,
  output logic [7:0]       position
);

  // Configuration.
  logic [13:0] ctrl;
  logic [23:0] tempo;
  logic        midi_clock_en;
  logic [1:0]  map_mode;
  logic        all_channels;
  logic [3:0]  channel;
  logic        gate_in_en;
  logic        clock_in_en;
  logic        ppqn24;
  logic [2:0]  op_mode;

  assign midi_clock_en = ctrl[midi_sync_pkg::MIDI_CLK_EN_BIT];
  assign map_mode      = ctrl[midi_sync_pkg::MAP_MODE_LSB +: 2];
  assign all_channels  = ctrl[midi_sync_pkg::ALL_CHAN_BIT];
  assign channel       = ctrl[midi_sync_pkg::CHANNEL_LSB +: 4];
  assign gate_in_en    = ctrl[midi_sync_pkg::GATE_EN_BIT];
  assign clock_in_en   = ctrl[midi_sync_pkg::CLOCK_EN_BIT];
  assign ppqn24        = ctrl[midi_sync_pkg::PPQN24_BIT];
  assign op_mode       = ctrl[midi_sync_pkg::OP_MODE_LSB +: 3];

  // APB slave with zero wait states; read data is captured in the setup cycle.
  logic       wr_access;
  logic       run_press_sw;
  logic       addr_hit;
  logic [1:0] clk_src;
  logic [2:0] pulse_cnt;
  logic [7:0] voice_trig_last;

  assign pready    = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign addr_hit  = paddr == midi_sync_pkg::CTRL_OFS || paddr == midi_sync_pkg::TEMPO_OFS ||
                     paddr == midi_sync_pkg::STATUS_OFS || paddr == midi_sync_pkg::RUN_OFS;
  assign run_press_sw = wr_access && paddr == midi_sync_pkg::RUN_OFS && pwdata[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl  <= midi_sync_pkg::CTRL_RESET;
      tempo <= midi_sync_pkg::TEMPO_RESET;
    end else if (wr_access) begin
      if (paddr == midi_sync_pkg::CTRL_OFS) begin
        ctrl <= pwdata[13:0];
      end
      // A zero period would stall the tempo divider, so it is held at one.
      if (paddr == midi_sync_pkg::TEMPO_OFS) begin
        tempo <= (pwdata[23:0] == 24'h000000) ? 24'h000001 : pwdata[23:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !addr_hit;
      unique case (paddr)
        midi_sync_pkg::CTRL_OFS:   prdata <= {18'h00000, ctrl};
        midi_sync_pkg::TEMPO_OFS:  prdata <= {8'h00, tempo};
        midi_sync_pkg::STATUS_OFS: prdata <= {voice_trig_last, 4'h0, 1'b0, pulse_cnt,
                                              position, 5'h00, clk_src, running};
        default:                   prdata <= 32'h00000000;
      endcase
    end
  end

  // Pin synchronisers and edge detection.
  logic clk_s1, clk_s2, clk_s3;
  logic gate_s1, gate_s2, gate_s3;
  logic ext_tick;
  logic gate_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {clk_s1, clk_s2, clk_s3}    <= 3'h0;
      {gate_s1, gate_s2, gate_s3} <= 3'h0;
    end else begin
      {clk_s1, clk_s2, clk_s3}    <= {clock_in_pin, clk_s1, clk_s2};
      {gate_s1, gate_s2, gate_s3} <= {gate_in_pin, gate_s1, gate_s2};
    end
  end

  assign ext_tick  = clock_in_en && clk_s2 && !clk_s3;
  assign gate_edge = gate_in_en && (gate_s2 != gate_s3);

  // MIDI parser with running status; real-time bytes pass through it untouched.
  logic [7:0] status;
  logic       data_idx;
  logic [6:0] first_data;
  logic       is_rt;
  logic       is_data;
  logic       two_bytes;
  logic       rt_ok;
  logic       midi_tick;
  logic       note_evt;
  logic       spp_zero;

  assign is_rt     = rx_valid && rx_data[7:3] == 5'h1F;
  assign is_data   = rx_valid && !rx_data[7];
  assign two_bytes = status[7:4] != 4'hC && status[7:4] != 4'hD &&
                     status != 8'hF1 && status != 8'hF3;
  assign rt_ok     = op_mode != midi_sync_pkg::OP_PLAY_DRUMS &&
                     op_mode != midi_sync_pkg::OP_EDIT_SONG;
  assign midi_tick = is_rt && rx_data == midi_sync_pkg::MIDI_CLOCK &&
                     rt_ok && midi_clock_en;
  assign note_evt  = is_data && data_idx && status[7:4] == midi_sync_pkg::NOTE_ON_HI &&
                     rx_data != 8'h00 && op_mode == midi_sync_pkg::OP_PLAY_DRUMS &&
                     (all_channels || status[3:0] == channel);
  assign spp_zero  = is_data && data_idx && status == midi_sync_pkg::MIDI_SONG_POS &&
                     rx_data == 8'h00 && first_data == 7'h00 && rt_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status     <= 8'h00;
      data_idx   <= 1'b0;
      first_data <= 7'h00;
    end else if (rx_valid && !is_rt) begin
      if (rx_data[7]) begin
        // System common bytes other than song position, F1 and F3 end running status.
        status   <= (rx_data[7:4] == 4'hF && rx_data != midi_sync_pkg::MIDI_SONG_POS &&
                     rx_data != 8'hF1 && rx_data != 8'hF3) ? 8'h00 : rx_data;
        data_idx <= 1'b0;
      end else if (status[7]) begin
        if (!data_idx && two_bytes) begin
          first_data <= rx_data[6:0];
          data_idx   <= 1'b1;
        end else begin
          data_idx <= 1'b0;
        end
      end
    end
  end

  // Note to voice mapping.
  function automatic logic [7:0] map_note(input logic [1:0] mode, input logic [6:0] note);
    logic [7:0] m;
    m = 8'h00;
    unique case (mode)
      midi_sync_pkg::MAP_ALL_DRUMS: begin
        case (note)
          7'd35, 7'd36:                             m = 8'h01;
          7'd41, 7'd43, 7'd45, 7'd61, 7'd64,
          7'd66, 7'd79:                             m = 8'h02;
          7'd47, 7'd48, 7'd50, 7'd60, 7'd62,
          7'd63, 7'd65, 7'd78:                      m = 8'h04;
          7'd38, 7'd40:                             m = 8'h08;
          7'd37, 7'd56, 7'd58, 7'd67, 7'd68,
          7'd71, 7'd72, 7'd75, 7'd76, 7'd77:        m = 8'h10;
          7'd39:                                    m = 8'h20;
          7'd42, 7'd44, 7'd54, 7'd69, 7'd70,
          7'd73, 7'd74, 7'd80:                      m = 8'h40;
          7'd46, 7'd49, 7'd51, 7'd52, 7'd53,
          7'd55, 7'd57, 7'd59, 7'd81:               m = 8'h80;
          default:                                  m = 8'h00;
        endcase
      end
      midi_sync_pkg::MAP_SPECIFIC: begin
        case (note)
          7'd36:   m = 8'h01;
          7'd38:   m = 8'h08;
          7'd39:   m = 8'h20;
          7'd42:   m = 8'h40;
          7'd43:   m = 8'h02;
          7'd46:   m = 8'h80;
          7'd50:   m = 8'h04;
          7'd76:   m = 8'h10;
          default: m = 8'h00;
        endcase
      end
      midi_sync_pkg::MAP_NOTES: begin
        case (7'(note % 7'd12))
          7'd0:    m = 8'h01;
          7'd2:    m = 8'h02;
          7'd4:    m = 8'h04;
          7'd5:    m = 8'h08;
          7'd7:    m = 8'h10;
          7'd9:    m = 8'h20;
          7'd11:   m = 8'h80;
          default: m = 8'h40;
        endcase
      end
      midi_sync_pkg::MAP_OCTAVES: begin
        case (7'(note / 7'd12))
          7'd0, 7'd1, 7'd2: m = 8'h01;
          7'd3:    m = 8'h02;
          7'd4:    m = 8'h04;
          7'd5:    m = 8'h08;
          7'd6:    m = 8'h10;
          7'd7:    m = 8'h20;
          7'd8:    m = 8'h40;
          7'd9:    m = 8'h80;
          default: m = 8'hC0;
        endcase
      end
    endcase
    return m;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      voice_trig      <= 8'h00;
      voice_trig_last <= 8'h00;
    end else begin
      voice_trig <= note_evt ? map_note(map_mode, first_data) : 8'h00;
      if (note_evt) begin
        voice_trig_last <= map_note(map_mode, first_data);
      end
    end
  end

  // Clock source selection; a source drops back after a silent timeout.
  logic [31:0] midi_idle;
  logic [31:0] ext_idle;
  logic        midi_active;
  logic        ext_active;
  logic [23:0] int_cnt;
  logic        int_tick;
  logic        midi_sel;
  logic        ext_sel;
  logic        tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      midi_active <= 1'b0;
      midi_idle   <= 32'h00000000;
      ext_active  <= 1'b0;
      ext_idle    <= 32'h00000000;
    end else begin
      if (midi_tick) begin
        midi_active <= 1'b1;
        midi_idle   <= 32'h00000000;
      end else if (!midi_clock_en || midi_idle == 32'(SOURCE_TIMEOUT_CYCLES)) begin
        midi_active <= 1'b0;
      end else if (midi_active) begin
        midi_idle <= midi_idle + 32'h00000001;
      end
      if (ext_tick) begin
        ext_active <= 1'b1;
        ext_idle   <= 32'h00000000;
      end else if (!clock_in_en || ext_idle == 32'(SOURCE_TIMEOUT_CYCLES)) begin
        ext_active <= 1'b0;
      end else if (ext_active) begin
        ext_idle <= ext_idle + 32'h00000001;
      end
    end
  end

  // The internal divider stands in for the tempo knob, one tick per 1/24 quarter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_cnt <= 24'h000000;
    end else if (int_cnt >= tempo - 24'h000001) begin
      int_cnt <= 24'h000000;
    end else begin
      int_cnt <= int_cnt + 24'h000001;
    end
  end

  assign int_tick = int_cnt >= tempo - 24'h000001;
  assign clk_src  = midi_active ? midi_sync_pkg::SRC_MIDI :
                    ext_active  ? midi_sync_pkg::SRC_EXTERNAL : midi_sync_pkg::SRC_INTERNAL;
  // The pulse that wakes a source already counts, so its first clock is never lost.
  assign midi_sel = midi_active || midi_tick;
  assign ext_sel  = !midi_sel && (ext_active || ext_tick);
  assign tick     = midi_sel ? midi_tick : ext_sel ? ext_tick : int_tick;

  // Transport and step counting.
  logic rt_start, rt_stop, rt_cont, run_press;

  assign rt_start  = is_rt && rt_ok && rx_data == midi_sync_pkg::MIDI_START;
  assign rt_stop   = is_rt && rt_ok && rx_data == midi_sync_pkg::MIDI_STOP;
  assign rt_cont   = is_rt && rt_ok && rx_data == midi_sync_pkg::MIDI_CONTINUE;
  assign run_press = run_press_sw || gate_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running    <= 1'b0;
      position   <= 8'h00;
      pulse_cnt  <= 3'h0;
      step_pulse <= 1'b0;
    end else begin
      step_pulse <= 1'b0;
      if (rt_stop || (run_press && running)) begin
        running <= 1'b0;
      end else if (rt_start || run_press) begin
        running   <= 1'b1;
        position  <= 8'h00;
        pulse_cnt <= 3'h0;
      end else if (rt_cont) begin
        running <= 1'b1;
      end else if (spp_zero) begin
        position  <= 8'h00;
        pulse_cnt <= 3'h0;
      end else if (running && tick) begin
        if (ext_sel && !ppqn24) begin
          step_pulse <= 1'b1;
          position   <= position + 8'h01;
        end else if (pulse_cnt == midi_sync_pkg::PULSES_PER_STEP - 3'h1) begin
          step_pulse <= 1'b1;
          position   <= position + 8'h01;
          pulse_cnt  <= 3'h0;
        end else begin
          pulse_cnt <= pulse_cnt + 3'h1;
        end
      end
    end
  end

  // Checks.
  chk_clock_off_dropped: assert property (@(posedge pclk) disable iff (!presetn)
    (is_rt && rx_data == midi_sync_pkg::MIDI_CLOCK && !midi_clock_en)
    |=> clk_src != midi_sync_pkg::SRC_MIDI)
    else $error("MIDI clock accepted while disabled");
  chk_stop_halts_now: assert property (@(posedge pclk) disable iff (!presetn)
    rt_stop |=> !running) else $error("Stop did not halt playback");
  chk_start_from_first: assert property (@(posedge pclk) disable iff (!presetn)
    (rt_start && !rt_stop && !run_press) |=> running && position == 8'h00 && pulse_cnt == 3'h0)
    else $error("Start did not rewind");
  chk_continue_keeps_pos: assert property (@(posedge pclk) disable iff (!presetn)
    (rt_cont && !rt_start && !rt_stop && !run_press) |=> running && $stable(position))
    else $error("Continue moved the position");
  chk_notes_drums_only: assert property (@(posedge pclk) disable iff (!presetn)
    voice_trig != 8'h00 |-> $past(op_mode) == midi_sync_pkg::OP_PLAY_DRUMS)
    else $error("Voice fired outside play-drums mode");
  chk_channel_filter: assert property (@(posedge pclk) disable iff (!presetn)
    (voice_trig != 8'h00 && !$past(all_channels)) |-> $past(status[3:0]) == $past(channel))
    else $error("Note accepted on wrong channel");
  chk_specific_bass: assert property (@(posedge pclk) disable iff (!presetn)
    (note_evt && map_mode == midi_sync_pkg::MAP_SPECIFIC && first_data == 7'd36)
    |=> voice_trig == 8'h01) else $error("Note 36 did not play bass drum");
  chk_six_pulse_step: assert property (@(posedge pclk) disable iff (!presetn)
    (step_pulse && $past(ppqn24)) |-> $past(pulse_cnt) == 3'h5)
    else $error("Step not on sixth pulse");
  chk_ext_step_each: assert property (@(posedge pclk) disable iff (!presetn)
    (running && tick && ext_sel && !ppqn24 && !rt_stop &&
     !rt_start && !rt_cont && !run_press && !spp_zero) |=> step_pulse)
    else $error("External pulse did not step");
  cov_midi_start: cover property (@(posedge pclk) disable iff (!presetn) rt_start ##[1:50] rt_stop);
  cov_note_played: cover property (@(posedge pclk) disable iff (!presetn) voice_trig != 8'h00);
  cov_ext_step: cover property (@(posedge pclk) disable iff (!presetn)
    step_pulse && clk_src == midi_sync_pkg::SRC_EXTERNAL);

endmodule

// *** logic/midi_sync_pkg.sv ***
// Constants, register map and encodings shared by the MIDI and sync input interpreter.
package midi_sync_pkg;

  // Clock rate and timing.
  localparam int unsigned CLK_KHZ           = 50_000;
  localparam int unsigned SOURCE_TIMEOUT_MS = 250;
  localparam int unsigned SOURCE_TIMEOUT_CYC = SOURCE_TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned DEFAULT_BPM       = 120;
  localparam int unsigned PULSES_PER_QUARTER = 24;
  localparam logic [2:0]  PULSES_PER_STEP   = 3'h6;
  localparam logic [23:0] TEMPO_RESET =
    24'((CLK_KHZ * 1000 * 60) / (DEFAULT_BPM * PULSES_PER_QUARTER));

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] TEMPO_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] RUN_OFS    = 8'h0C;

  // Control register field positions and reset value.
  localparam int unsigned MIDI_CLK_EN_BIT  = 0;
  localparam int unsigned MAP_MODE_LSB     = 1;
  localparam int unsigned ALL_CHAN_BIT     = 3;
  localparam int unsigned CHANNEL_LSB      = 4;
  localparam int unsigned GATE_EN_BIT      = 8;
  localparam int unsigned CLOCK_EN_BIT     = 9;
  localparam int unsigned PPQN24_BIT       = 10;
  localparam int unsigned OP_MODE_LSB      = 11;
  localparam logic [13:0] CTRL_RESET       = 14'h0709;

  // MIDI bytes.
  localparam logic [7:0] MIDI_CLOCK    = 8'hF8;
  localparam logic [7:0] MIDI_START    = 8'hFA;
  localparam logic [7:0] MIDI_CONTINUE = 8'hFB;
  localparam logic [7:0] MIDI_STOP     = 8'hFC;
  localparam logic [7:0] MIDI_SONG_POS = 8'hF2;
  localparam logic [3:0] NOTE_ON_HI    = 4'h9;

  typedef enum logic [1:0] {
    MAP_ALL_DRUMS = 2'b00,
    MAP_SPECIFIC  = 2'b01,
    MAP_NOTES     = 2'b10,
    MAP_OCTAVES   = 2'b11
  } map_mode_t;

  typedef enum logic [2:0] {
    OP_PLAY_DRUMS  = 3'b000,
    OP_PLAY_SONGS  = 3'b001,
    OP_PLAY_PATS   = 3'b010,
    OP_EDIT_PATS   = 3'b011,
    OP_WRITE_PATS  = 3'b100,
    OP_EDIT_SONG   = 3'b101,
    OP_EDIT_TRIGS  = 3'b110,
    OP_SETUP       = 3'b111
  } op_mode_t;

  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'b00,
    SRC_EXTERNAL = 2'b01,
    SRC_MIDI     = 2'b10
  } clk_src_t;

  // Voice bit positions in a voice mask.
  localparam int unsigned BASS_DRUM_VOICE = 0;
  localparam int unsigned LOW_TOM_VOICE   = 1;
  localparam int unsigned HIGH_TOM_VOICE  = 2;
  localparam int unsigned SNARE_VOICE     = 3;
  localparam int unsigned WOOD_BLOCK_VOICE = 4;
  localparam int unsigned HAND_CLAP_VOICE = 5;
  localparam int unsigned CLOSED_HAT_VOICE = 6;
  localparam int unsigned OPEN_HAT_VOICE  = 7;

endpackage

// *** tb/midi_source.sv ***
// Model of an external MIDI device and modular clock source driving the interpreter.
`timescale 1ns/1ns
module midi_source (
  // Clock.
  input  wire logic       pclk,
  // Received MIDI bytes.
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  // Sync pins.
  output logic            clock_in_pin,
  output logic            gate_in_pin
);
  initial begin
    rx_data      = 8'h00;
    rx_valid     = 1'b0;
    clock_in_pin = 1'b0;
    gate_in_pin  = 1'b0;
  end

  // Idle data carries the inverse of the last byte so a stale byte never looks valid.
  task automatic send(input logic [7:0] b);
    @(posedge pclk);
    rx_data  <= b;
    rx_valid <= 1'b1;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data  <= ~b;
  endtask

  // Clock pulses at 24 per quarter, each held three cycles high and four low.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      clock_in_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      clock_in_pin <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  task automatic gate(input logic v);
    @(posedge pclk);
    gate_in_pin <= v;
    repeat (6) @(posedge pclk);
  endtask
endmodule

// *** tb/midi_sync_interpreter_bench.sv ***
// Self-checking bench for the MIDI and sync input interpreter.
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module midi_sync_interpreter_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        clock_in_pin;
  logic        gate_in_pin;
  logic [7:0]  voice_trig;
  logic        step_pulse;
  logic        running;
  logic [7:0]  position;
  int          fail_count = 0;
  int          n_compared = 0;
  int          steps = 0;
  logic [31:0] r;
  logic        e;
  logic [7:0]  m;
  localparam logic [7:0] SN [8] = '{8'h24, 8'h26, 8'h27, 8'h2A, 8'h2B, 8'h2E, 8'h32, 8'h4C};
  localparam logic [7:0] SM [8] = '{8'h01, 8'h08, 8'h20, 8'h40, 8'h02, 8'h80, 8'h04, 8'h10};
  localparam logic [7:0] NM [12] = '{8'h01, 8'h40, 8'h02, 8'h40, 8'h04, 8'h08, 8'h40,
                                     8'h10, 8'h40, 8'h20, 8'h40, 8'h80};
  localparam logic [7:0] OM [11] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
                                     8'h20, 8'h40, 8'h80, 8'hC0};

  always #10 pclk = ~pclk;
  always @(posedge pclk) if (step_pulse === 1'b1) steps++;

  midi_sync_interpreter #(
    .SOURCE_TIMEOUT_CYCLES(200)
  ) u_dut (
    .pclk         (pclk),
    .presetn      (presetn),
    .paddr        (paddr),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .rx_data      (rx_data),
    .rx_valid     (rx_valid),
    .clock_in_pin (clock_in_pin),
    .gate_in_pin  (gate_in_pin),
    .voice_trig   (voice_trig),
    .step_pulse   (step_pulse),
    .running      (running),
    .position     (position)
  );

  midi_source u_src (
    .pclk         (pclk),
    .rx_data      (rx_data),
    .rx_valid     (rx_valid),
    .clock_in_pin (clock_in_pin),
    .gate_in_pin  (gate_in_pin)
  );

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      fail_count++;
      results();
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // Sends a note-on and gathers every voice pulse seen in the next three cycles.
  task automatic hit(input logic [7:0] st, input logic [7:0] nt, input logic [7:0] vel);
    m = 8'h00;
    u_src.send(st);
    u_src.send(nt);
    u_src.send(vel);
    repeat (3) begin
      #1;
      m = m | voice_trig;
      @(posedge pclk);
    end
  endtask

  task automatic t_reset();
    apb(1'b0, midi_sync_pkg::CTRL_OFS, 32'h0);
    `CHK(r, 32'h0000_0709)
    apb(1'b0, midi_sync_pkg::TEMPO_OFS, 32'h0);
    `CHK(r, 32'(midi_sync_pkg::TEMPO_RESET))
    // A zero period is stored as one; the reset period is put back afterwards.
    apb(1'b1, midi_sync_pkg::TEMPO_OFS, 32'h00000000);
    apb(1'b0, midi_sync_pkg::TEMPO_OFS, 32'h00000000);
    `CHK(r, 32'h00000001)
    apb(1'b1, midi_sync_pkg::TEMPO_OFS, 32'(midi_sync_pkg::TEMPO_RESET));
    apb(1'b0, 8'h10, 32'h0);
    `CHK(e, 1'b1)
  endtask

  task automatic t_maps();
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h070B);
    for (int i = 0; i < 8; i++) begin
      hit(8'h90, SN[i], 8'h7F);
      `CHK(m, SM[i])
    end
    hit(8'h90, 8'h25, 8'h7F);
    `CHK(m, 8'h00)
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h070D);
    for (int i = 0; i < 12; i++) begin
      hit(8'h90, 8'(12 * (i % 9) + i), 8'h40);
      `CHK(m, NM[i])
    end
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h070F);
    for (int i = 0; i < 11; i++) begin
      hit(8'h90, 8'(12 * i + i % 7), 8'h40);
      `CHK(m, OM[i])
    end
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h0709);
    hit(8'h90, 8'h24, 8'h7F);
    `CHK(m, 8'h01)
  endtask

  task automatic t_channel();
    hit(8'h9F, 8'h24, 8'h7F);
    `CHK(m, 8'h01)
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h0723);
    hit(8'h92, 8'h24, 8'h7F);
    `CHK(m, 8'h01)
    hit(8'h91, 8'h24, 8'h7F);
    `CHK(m, 8'h00)
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h0F0B);
    hit(8'h90, 8'h24, 8'h7F);
    `CHK(m, 8'h00)
  endtask

  task automatic t_transport();
    int s;
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h0709);
    u_src.send(8'hFA);
    settle(3);
    `CHK(running, 1'b0)
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h1709);
    u_src.send(8'hFA);
    settle(3);
    `CHK({running, position}, 9'h100)
    s = steps;
    repeat (6) u_src.send(8'hF8);
    settle(3);
    `CHK(position, 8'h01)
    `CHK(steps - s, 1)
    u_src.send(8'hFC);
    settle(2);
    `CHK(running, 1'b0)
    u_src.send(8'hFB);
    settle(3);
    `CHK({running, position}, 9'h101)
    // Status: last voice bass, pulse count 0, position 1, source MIDI, running.
    apb(1'b0, midi_sync_pkg::STATUS_OFS, 32'h00000000);
    `CHK(r, 32'h01000105)
    u_src.send(8'hFC);
    foreach (SN[i]) if (i < 3) u_src.send(i == 1 ? 8'h05 : (i == 0 ? 8'hF2 : 8'h00));
    u_src.send(8'hFB);
    settle(3);
    `CHK(position, 8'h01)
    u_src.send(8'hFC);
    foreach (SN[i]) if (i < 3) u_src.send(i == 0 ? 8'hF2 : 8'h00);
    u_src.send(8'hFB);
    settle(3);
    `CHK({running, position}, 9'h100)
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h3F08);
    u_src.send(8'hFA);
    repeat (6) u_src.send(8'hF8);
    settle(3);
    `CHK({running, position}, 9'h100)
    u_src.send(8'hFC);
  endtask

  task automatic t_sync();
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h1709);
    settle(260);
    apb(1'b1, midi_sync_pkg::RUN_OFS, 32'h1);
    u_src.tick(6);
    settle(4);
    `CHK({running, position}, 9'h101)
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h1309);
    u_src.tick(2);
    settle(4);
    `CHK(position, 8'h03)
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h1509);
    u_src.tick(6);
    settle(4);
    `CHK(position, 8'h03)
    apb(1'b1, midi_sync_pkg::RUN_OFS, 32'h1);
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h1709);
    u_src.gate(1'b1);
    `CHK(running, 1'b1)
    u_src.gate(1'b0);
    `CHK(running, 1'b0)
    apb(1'b1, midi_sync_pkg::CTRL_OFS, 32'h1609);
    u_src.gate(1'b1);
    `CHK(running, 1'b0)
  endtask

  initial begin
    paddr   = 8'h00;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h00000000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_maps();
    t_channel();
    t_transport();
    t_sync();
    results();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    results();
  end
endmodule
